// ==== design/pot_spi_pkg.sv ====
// Package: constants for the dual potentiometer serial slave port.
// Assumes a single 25 MHz system clock that oversamples the serial pins.
package pot_spi_pkg;
  // Instruction byte layout
  localparam int INSTR_MSB      = 7;
  localparam int INSTR_LSB      = 5;
  localparam int ADDR_MSB       = 4;
  localparam int ADDR_LSB       = 0;
  localparam logic [2:0] INSTR_READ  = 3'h3;
  localparam logic [2:0] INSTR_WRITE = 3'h2;
  localparam logic [4:0] ADDR_POT0   = 5'h00;
  localparam logic [4:0] ADDR_POT1   = 5'h01;
  localparam logic [4:0] ADDR_ACR    = 5'h10;
  // Access control register fields
  localparam int ACR_VOL_BIT    = 7;
  localparam int ACR_SHDN_BIT   = 6;
  localparam int ACR_BUSY_BIT   = 5;
  localparam int ACR_OD_BIT     = 1;
  localparam logic [7:0] ACR_WMASK   = 8'hc2;
  localparam logic [7:0] ACR_RESET   = 8'h40;
  localparam logic [7:0] WIPER_RESET = 8'h80;
  localparam logic [7:0] WIPER_HIGH  = 8'hff;
  localparam logic [7:0] WIPER_LOW   = 8'h00;
  localparam int BITS_PER_BYTE  = 8;
  // Timing
  localparam int CLOCK_HZ       = 25000000;
  localparam int NV_WRITE_MS    = 20;
  localparam int NV_WRITE_CYCLES = (CLOCK_HZ / 1000) * NV_WRITE_MS;
  // Port state machine
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_INSTR = 3'b010,
    ST_DATA  = 3'b100
  } port_state_t;
endpackage : pot_spi_pkg

// ==== design/nv_write_timer.sv ====
// Self-timed non-volatile write cycle timer.
// Assumes start is a one-cycle pulse on the system clock.
`timescale 1ns/100ps
`default_nettype none
module nv_write_timer #(
  parameter int CYCLES = 500000            // Length of write cycle
) (
  input  wire logic i_clock,               // System clock
  input  wire logic i_rst,                 // Async reset, high
  input  wire logic i_enable,              // Clock enable
  input  wire logic i_start,               // Start pulse
  output logic      o_busy                 // Write in progress
);
  typedef struct packed {
    logic        busy;
    logic [31:0] count;
  } timer_t;
  timer_t s_q;
  timer_t s_d;

  // Count down once started; no serial clocks needed
  always_comb
  begin
    s_d = s_q;
    if (i_start)
    begin
      s_d.busy  = 1'b1;
      s_d.count = 32'(CYCLES - 1);
    end
    else if (s_q.busy)
    begin
      if (s_q.count == 32'h0)
        s_d.busy = 1'b0;
      else
        s_d.count = s_q.count - 32'h1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      s_q <= '0;
    else if (i_enable)
      s_q <= s_d;
  end

  assign o_busy = s_q.busy;
endmodule // nv_write_timer
`default_nettype wire

// ==== design/dual_pot_spi_slave_port.sv ====
// Serial slave port of a dual digital potentiometer: mode 0 SPI, byte
// framing, register access and non-volatile write control.
// Assumes the serial pins are asynchronous and slow against i_clock.
//
// Overview of operation
// - Input bits are taken at the serial clock's rising edge while select is low.
// - Read bits leave on the falling edge so the host samples them on the next rise.
// - Access control bit 1 picks open-drain output, push-pull by default.
// - Select low makes the device active.
// - While deselected the serial output is released to high impedance.
// - Deselected means standby, delayed until a running write cycle ends.
// - Wiper code 255 sits at the high terminal and 0 at the low terminal.
// - The non-volatile write is self-timed from the end of the write sequence.
// - The first byte holds a 3-bit instruction and a 5-bit register address.
// - Every byte travels most significant bit first.
// - A write executes only at the rising edge of select that ends it.
// - Access control bit 5 reads busy during a write and stays pollable.
`timescale 1ns/100ps
`default_nettype none
module dual_pot_spi_slave_port #(
  parameter int NV_CYCLES = pot_spi_pkg::NV_WRITE_CYCLES  // Write cycle length
) (
  input  wire logic       i_clock,         // 25 MHz system clock
  input  wire logic       i_rst,           // Async reset, high
  input  wire logic       i_enable,        // Clock enable
  input  wire logic       i_sck,           // Serial clock pin
  input  wire logic       i_cs_n,          // Chip select pin, low
  input  wire logic       i_sdi,           // Serial data in pin
  output logic            o_sdo,           // Serial data out level
  output logic            o_sdo_oe_n,      // Output enable, low drives
  output logic            o_active,        // Active power mode
  output logic [7:0]      o_wiper0,        // Wiper 0 tap code
  output logic [7:0]      o_wiper1,        // Wiper 1 tap code
  output logic            o_shutdown       // Shutdown request
);
  import pot_spi_pkg::*;

  //--------------------------------------------------------------
  // State
  //--------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  sck_s;
    logic [1:0]  cs_s;
    logic [1:0]  sdi_s;
    logic        sck_p;
    logic        cs_p;
    logic        armed;
    port_state_t st;
    logic [2:0]  bitcnt;
    logic [7:0]  shreg;
    logic [2:0]  instr;
    logic [4:0]  addr;
    logic        have_data;
    logic [7:0]  wdata;
    logic [7:0]  txreg;
    logic        sdo;
    logic        oe_n;
    logic        active;
    logic [7:0]  access_control_reg;
    logic [7:0]  wiper0;
    logic [7:0]  wiper1;
    logic [7:0]  ivr0;
    logic [7:0]  ivr1;
    logic        nv_go;
    logic        shdn;
  } port_t;
  port_t s_q;
  port_t s_d;
  logic  nv_busy;

  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic [7:0] shifted;
  logic [7:0] read_val;

  //--------------------------------------------------------------
  // Write cycle timer
  //--------------------------------------------------------------
  nv_write_timer #(.CYCLES(NV_CYCLES)) u_timer (
    .i_clock  (i_clock),
    .i_rst    (i_rst),
    .i_enable (i_enable),
    .i_start  (s_q.nv_go),
    .o_busy   (nv_busy)
  );

  // Edges from the second synchroniser stage only
  assign sck_rise = s_q.sck_s[1] & ~s_q.sck_p;
  assign sck_fall = ~s_q.sck_s[1] & s_q.sck_p;
  assign cs_fall  = ~s_q.cs_s[1] & s_q.cs_p;
  assign cs_rise  = s_q.cs_s[1] & ~s_q.cs_p;
  assign shifted  = {s_q.shreg[6:0], s_q.sdi_s[1]};

  // Read data; busy bit live, pot reads give the wiper if bit 7 is set, else the non-volatile copy
  always_comb
  begin
    read_val = 8'h00;
    case (s_q.addr)
      ADDR_ACR:  read_val = {s_q.access_control_reg[7:6], nv_busy, 3'h0, s_q.access_control_reg[ACR_OD_BIT], 1'b0};
      ADDR_POT0: read_val = s_q.access_control_reg[ACR_VOL_BIT] ? s_q.wiper0 : s_q.ivr0;
      ADDR_POT1: read_val = s_q.access_control_reg[ACR_VOL_BIT] ? s_q.wiper1 : s_q.ivr1;
      default:   read_val = 8'h00;
    endcase
  end

  //--------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.sck_s = {s_q.sck_s[0], i_sck};
    s_d.cs_s  = {s_q.cs_s[0], i_cs_n};
    s_d.sdi_s = {s_q.sdi_s[0], i_sdi};
    s_d.sck_p = s_q.sck_s[1];
    s_d.cs_p  = s_q.cs_s[1];
    s_d.nv_go = 1'b0;
    // Standby only once any write cycle has finished
    s_d.active = ~s_q.cs_s[1] | nv_busy;
    case (s_q.st)
      ST_IDLE:
      begin
        if (cs_fall)
        begin
          s_d.armed     = 1'b1;
          s_d.st        = ST_INSTR;
          s_d.bitcnt    = 3'h0;
          s_d.have_data = 1'b0;
        end
      end
      ST_INSTR, ST_DATA:
      begin
        if (cs_rise)
        begin
          // Only complete bytes count; execute the write now
          if (s_q.have_data && s_q.instr == INSTR_WRITE && !nv_busy)
          begin
            case (s_q.addr)
              ADDR_ACR: s_d.access_control_reg = (s_q.access_control_reg & ~ACR_WMASK) | (s_q.wdata & ACR_WMASK);
              ADDR_POT0:
              begin
                s_d.wiper0 = s_q.wdata;
                if (!s_q.access_control_reg[ACR_VOL_BIT])
                begin
                  s_d.ivr0  = s_q.wdata;
                  s_d.nv_go = 1'b1;
                end
              end
              ADDR_POT1:
              begin
                s_d.wiper1 = s_q.wdata;
                if (!s_q.access_control_reg[ACR_VOL_BIT])
                begin
                  s_d.ivr1  = s_q.wdata;
                  s_d.nv_go = 1'b1;
                end
              end
              default: s_d.access_control_reg = s_q.access_control_reg;
            endcase
          end
          s_d.st = ST_IDLE;
        end
        else if (sck_rise)
        begin
          s_d.shreg  = shifted;
          s_d.bitcnt = s_q.bitcnt + 3'h1;
          if (s_q.bitcnt == 3'(BITS_PER_BYTE - 1))
          begin
            if (s_q.st == ST_INSTR)
            begin
              s_d.instr = shifted[INSTR_MSB:INSTR_LSB];
              s_d.addr  = shifted[ADDR_MSB:ADDR_LSB];
              s_d.st    = ST_DATA;
            end
            else
            begin
              s_d.wdata     = shifted;
              s_d.have_data = 1'b1;
            end
          end
        end
        else if (sck_fall && s_q.st == ST_DATA && s_q.instr == INSTR_READ)
        begin
          // Load on the first fall of the data byte, then shift
          if (s_q.bitcnt == 3'h0)
          begin
            s_d.sdo   = read_val[7];
            s_d.txreg = {read_val[6:0], 1'b0};
          end
          else
          begin
            s_d.sdo   = s_q.txreg[7];
            s_d.txreg = {s_q.txreg[6:0], 1'b0};
          end
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    // Output driver: released when deselected, open drain drives low only
    if (s_q.cs_s[1] || !s_q.armed)
      s_d.oe_n = 1'b1;
    else if (s_q.access_control_reg[ACR_OD_BIT])
      s_d.oe_n = s_d.sdo;
    else
      s_d.oe_n = 1'b0;
    s_d.shdn = ~s_d.access_control_reg[ACR_SHDN_BIT];                            // Shutdown output from a flop
  end

  //--------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_q        <= '0;  // Select starts low: held low through reset is no falling edge
      s_q.st     <= ST_IDLE;
      s_q.oe_n   <= 1'b1;
      s_q.access_control_reg    <= ACR_RESET;
      s_q.wiper0 <= WIPER_RESET;
      s_q.wiper1 <= WIPER_RESET;
      s_q.ivr0   <= WIPER_RESET;
      s_q.ivr1   <= WIPER_RESET;
    end
    else if (i_enable)
      s_q <= s_d;
  end

  assign o_sdo      = s_q.sdo;
  assign o_sdo_oe_n = s_q.oe_n;
  assign o_active   = s_q.active;
  assign o_wiper0   = s_q.wiper0;
  assign o_wiper1   = s_q.wiper1;
  assign o_shutdown = s_q.shdn;

  //--------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------
  property p_release;
    @(posedge i_clock) disable iff (i_rst)
      (i_enable && s_q.cs_s[1]) |=> o_sdo_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("sdo driven while deselected");

  property p_od;
    @(posedge i_clock) disable iff (i_rst)
      (!o_sdo_oe_n && s_q.access_control_reg[ACR_OD_BIT] && $stable(s_q.access_control_reg)) |-> !o_sdo;
  endproperty
  a_od: assert property (p_od) else $error("open drain drove high");

  property p_active;
    @(posedge i_clock) disable iff (i_rst)
      (i_enable && !s_q.cs_s[1]) |=> o_active;
  endproperty
  a_active: assert property (p_active) else $error("not active while selected");

  property p_standby;
    @(posedge i_clock) disable iff (i_rst)
      (i_enable && s_q.cs_s[1] && !nv_busy) |=> !o_active;
  endproperty
  a_standby: assert property (p_standby) else $error("no standby when idle");

  property p_arm;
    @(posedge i_clock) disable iff (i_rst)
      !s_q.armed |-> s_q.st == ST_IDLE;
  endproperty
  a_arm: assert property (p_arm) else $error("traffic before first select");

  property p_wiper_hold;
    @(posedge i_clock) disable iff (i_rst)
      (i_enable && !cs_rise) |=> $stable(o_wiper0) && $stable(o_wiper1);
  endproperty
  a_wiper_hold: assert property (p_wiper_hold) else $error("wiper changed mid frame");

  property p_partial;
    @(posedge i_clock) disable iff (i_rst)
      (i_enable && cs_rise && !s_q.have_data) |=> $stable(s_q.access_control_reg) && !s_q.nv_go;
  endproperty
  a_partial: assert property (p_partial) else $error("partial byte executed");

  property p_busy;
    @(posedge i_clock) disable iff (i_rst)
      (i_enable && s_q.nv_go) |=> nv_busy [*8];
  endproperty
  a_busy: assert property (p_busy) else $error("write cycle not busy");

  property p_sdo_fall;
    @(posedge i_clock) disable iff (i_rst)
      (i_enable && !sck_fall) |=> $stable(o_sdo);
  endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("sdo moved off falling edge");
endmodule // dual_pot_spi_slave_port
`default_nettype wire

// ==== verif/pot_spi_host.sv ====
// SPI host model for the potentiometer port, mode 0, clock idles low.
// Assumes an external pull-up on the serial output pin.
`timescale 1ns/100ps
`default_nettype none
module pot_spi_host (
  input  wire logic i_clock,    // System clock
  input  wire logic i_sdo,      // Device output level
  input  wire logic i_sdo_oe_n, // Device drive enable, low
  output logic      o_sck,      // Serial clock
  output logic      o_cs_n,     // Chip select, low
  output logic      o_sdi       // Serial data to device
);
  logic pin;
  // Released pin floats to the pull-up level
  assign pin = i_sdo_oe_n ? 1'b1 : i_sdo;
  initial
  begin
    o_sck  = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
  end
  // Wait n clocks, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #2;
  endtask
  // Select with no frame, used while reset is held
  task automatic select();
    o_cs_n = 1'b0;
  endtask
  // End a frame and leave the select gap
  task automatic deselect();
    tick(8);
    o_cs_n = 1'b1;
    tick(16);
  endtask
  // Send n bits of w MSB first and sample the second byte
  task automatic frame(input logic [15:0] w, input int n, input bit keep,
                       output logic [7:0] rd);
    rd     = 8'h00;
    o_cs_n = 1'b0;
    tick(8);
    for (int i = 15; i > 15 - n; i--)
    begin
      o_sdi = w[i];
      tick(8);
      o_sck = 1'b1;
      if (i < 8) rd[i] = pin;
      tick(8);
      o_sck = 1'b0;
    end
    // Data line no longer holds the last bit
    o_sdi = ~o_sdi;
    if (!keep) deselect();
  endtask
endmodule // pot_spi_host
`default_nettype wire

// ==== verif/dual_pot_spi_slave_port_tb.sv ====
// Self-checking bench for the potentiometer serial port.
// Assumes the host model drives the pins; write cycle shortened.
`timescale 1ns/100ps
`default_nettype none
module dual_pot_spi_slave_port_tb;
  import pot_spi_pkg::*;
  localparam int NV = 1000;
  logic       i_clock, i_rst, sck, cs_n, sdi;
  logic       sdo, sdo_oe_n, active, shutdown;
  logic [7:0] wiper0, wiper1, rd;
  int         n_fail = 0;
  int         num_checks = 0;
  int         hold_cnt = 0;
  bit         od = 1'b0;
  bit         en = 1'b1;
  // --------------------------------------------------------------
  // Design and host
  // --------------------------------------------------------------
  dual_pot_spi_slave_port #(.NV_CYCLES(NV)) u_dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_enable(en), .i_sck(sck),
    .i_cs_n(cs_n), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n),
    .o_active(active), .o_wiper0(wiper0), .o_wiper1(wiper1),
    .o_shutdown(shutdown));
  pot_spi_host u_host (
    .i_clock(i_clock), .i_sdo(sdo), .i_sdo_oe_n(sdo_oe_n),
    .o_sck(sck), .o_cs_n(cs_n), .o_sdi(sdi));
  // 25 MHz clock
  initial
  begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    u_host.frame({INSTR_WRITE, a, d}, 16, 1'b0, rd);
  endtask
  task automatic rdreg(input logic [4:0] a);
    u_host.frame({INSTR_READ, a, 8'h00}, 16, 1'b0, rd);
  endtask
  // Pin watch: released soon after deselect, open drain never drives high
  always @(posedge i_clock)
  begin
    hold_cnt <= (cs_n && !sdo_oe_n) ? hold_cnt + 1 : 0;
    if (hold_cnt == 6) check("sdo released", 8'h01, 8'h00);
    if (od && !sdo_oe_n && sdo === 1'b1) check("od drive", 8'h00, 8'h01);
  end
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    check("wiper0", WIPER_RESET, wiper0);
    check("wiper1", WIPER_RESET, wiper1);
    check("active", 8'h00, {7'h0, active});
    check("oe_n", 8'h01, {7'h0, sdo_oe_n});
    // Select already low at release: no falling edge, frame ignored
    wr(ADDR_POT0, 8'h11);
    check("unarmed wiper0", WIPER_RESET, wiper0);
    $display("t_reset done");
  endtask
  task automatic t_acr();
    wr(ADDR_ACR, 8'hbf);
    od = 1'b1;
    check("shutdown", 8'h01, {7'h0, shutdown});
    check("standby", 8'h00, {7'h0, active});
    rdreg(ADDR_ACR);
    check("acr od", 8'hbf & ACR_WMASK, rd);
    wr(ADDR_ACR, 8'hc0);
    od = 1'b0;
    check("shutdown off", 8'h00, {7'h0, shutdown});
    $display("t_acr done");
  endtask
  task automatic t_wiper();
    wr(ADDR_POT0, WIPER_HIGH);
    check("wiper0 high", 8'hff, wiper0);
    wr(ADDR_POT1, WIPER_LOW);
    check("wiper1 low", 8'h00, wiper1);
    u_host.frame({INSTR_WRITE, ADDR_POT1, 8'h5a}, 16, 1'b1, rd);
    check("before cs rise", 8'h00, wiper1);
    check("active", 8'h01, {7'h0, active});
    u_host.deselect();
    check("after cs rise", 8'h5a, wiper1);
    u_host.frame({INSTR_WRITE, ADDR_POT1, 8'ha5}, 12, 1'b0, rd);
    check("partial byte", 8'h5a, wiper1);
    rdreg(ADDR_POT1);
    check("read wiper1", 8'h5a, rd);
    $display("t_wiper done");
  endtask
  // Clock enable low: a whole frame passes unseen
  task automatic t_freeze();
    en = 1'b0;
    wr(ADDR_POT1, 8'h33);
    en = 1'b1;
    u_host.tick(4);
    check("frozen wiper1", 8'h5a, wiper1);
    $display("t_freeze done");
  endtask
  task automatic t_nv();
    int i;
    wr(ADDR_ACR, 8'h40);
    wr(ADDR_POT0, 8'h3c);
    check("nv wiper0", 8'h3c, wiper0);
    check("busy active", 8'h01, {7'h0, active});
    rdreg(ADDR_ACR);
    check("acr busy", 8'h60, rd);
    // Writes are refused while the cycle runs
    wr(ADDR_POT1, 8'h77);
    check("busy refused", 8'h5a, wiper1);
    // Write cycle ends with no serial clocks
    i = 0;
    while (active === 1'b1 && i < 2 * NV)
    begin
      @(posedge i_clock);
      i++;
    end
    #2;
    check("nv done", 8'h00, {7'h0, active});
    if (i >= 2 * NV) end_of_test();
    rdreg(ADDR_ACR);
    check("acr idle", 8'h40, rd);
    rdreg(ADDR_POT0);
    check("ivr0 read", 8'h3c, rd);
    $display("t_nv done");
  endtask
  // --------------------------------------------------------------
  // Run
  // --------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    i_rst = 1'b1;
    #1;
    u_host.select();
    repeat (8) @(posedge i_clock);
    #2;
    i_rst = 1'b0;
    t_reset();
    t_acr();
    t_wiper();
    t_freeze();
    t_nv();
    end_of_test();
  end
endmodule // dual_pot_spi_slave_port_tb
`default_nettype wire
